// >>> design/pin_mux_regs.vh
`ifndef PIN_MUX_REGS_VH
`define PIN_MUX_REGS_VH

`define NUM_PINS        66
`define NUM_MSETS       9
`define NUM_CSETS       3
`define NUM_ROUTES      21
`define PIN_OSC         63
`define PIN_NOROUTE_A   6'd39
`define PIN_NOROUTE_B   6'd44
`define PIN_VBUS        38
`define PIN_DMINUS      42
`define PIN_DPLUS       45
`define PIN_ID          46

`define ADR_MSET_MAX    10'h090
`define ADR_CSET_BASE   10'h200
`define ADR_CSET_MAX    10'h230
`define ADR_AMSEL       10'h100
`define ADR_LPSTAT      10'h104
`define ADR_QUAL0       10'h300
`define ADR_QUAL1       10'h304
`define ADR_QUAL2       10'h308
`define ADR_CLKCFG      10'h30c
`define ADR_WAKESEL     10'h310
`define ADR_STATUS      10'h314
`define ADR_ROUTE_BASE  10'h320
`define ADR_ROUTE_MAX   10'h338

`define SUB_FUNC        2'd0
`define SUB_PATH        2'd1
`define SUB_DATA        2'd2
`define SUB_PULL        2'd3

`define CLK_LPM_LSB     0
`define CLK_QUAL_LSB    2
`define CLK_WAKEIE_BIT  8
`define LPM_IDLE        2'b00
`define LPM_STANDBY     2'b01
`define RESET_VALUE     32'h0000_0000
`define WAKE_CNT_MAX    7'h7f

`endif

// >>> design/pin_mux_wake.v
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_regs.vh"

module pin_mux_wake #(
	parameter SILICON_REV0 = 0
) (
	input  wire          clk_i,
	input  wire          reset_i,
	input  wire          wb_cyc_i,
	input  wire          wb_stb_i,
	input  wire          wb_we_i,
	input  wire [9:0]    wb_adr_i,
	input  wire [3:0]    wb_sel_i,
	input  wire [31:0]   wb_dat_i,
	output wire [31:0]   wb_dat_o,
	output wire          wb_ack_o,
	input  wire [65:0]   pin_in_i,
	output wire [65:0]   pin_out_o,
	output wire [65:0]   pin_oe_o,
	output wire [65:0]   pin_pullup_o,
	output wire [3:0]    usb_analog_en_o,
	output wire          usb_pll_ref_clock_o,
	output wire          can_ext_clock_o,
	input  wire [989:0]  m_per_out_i,
	input  wire [989:0]  m_per_oe_i,
	output wire [65:0]   m_pin_in_o,
	input  wire [197:0]  c_per_out_i,
	input  wire [197:0]  c_per_oe_i,
	output wire [65:0]   c_pin_in_o,
	output wire [8:0]    port_group_irq_o,
	output wire [11:0]   pin_trip_events_o,
	output wire [5:0]    capture_in_o,
	output wire [2:0]    ext_int_o,
	output wire [65:0]   control_general_inputs_o,
	output wire          standby_wake_signal_o,
	input  wire          idle_strobe_i,
	input  wire          control_irq_i,
	input  wire          master_to_control_ipc_irq2_i,
	output wire          control_input_clock_en_o,
	output wire          control_core_clock_en_o,
	output wire          control_system_clock_en_o,
	output wire          wake_irq_o,
	output wire          resume_o
);
	localparam ST_RUN  = 3'b001;
	localparam ST_IDLE = 3'b010;
	localparam ST_STBY = 3'b100;

	// M-set fields are sized for full 8-pin sets, C-set fields for 32-pin sets; pins 66 and up do not exist
	reg  [287:0] port_function_select_reg;
	reg  [71:0]  alternate_path_select_reg;
	reg  [71:0]  m_data_reg;
	reg  [71:0]  m_dir_reg;
	reg  [71:0]  pullup_reg;
	reg  [71:0]  irq_en_reg;
	reg  [191:0] c_mux_reg;
	reg  [95:0]  c_data_reg;
	reg  [95:0]  c_dir_reg;
	reg  [3:0]   analog_mode_select_reg;
	reg  [1:0]   control_lowpower_status_reg;
	reg  [71:0]  qual_period_reg;
	reg  [8:0]   control_clock_config_reg;
	reg  [5:0]   wake_sel_reg;
	reg  [191:0] route_sel_reg;
	reg  [65:0]  pin_meta_reg;
	reg  [65:0]  pin_sync_reg;
	reg  [65:0]  out_reg;
	reg  [65:0]  oe_reg;
	reg  [65:0]  pull_out_reg;
	reg  [65:0]  m_in_reg;
	reg  [65:0]  c_in_reg;
	reg  [8:0]   group_irq_reg;
	reg  [20:0]  route_reg;
	reg  [6:0]   wake_cnt_reg;
	reg  [2:0]   state_reg;
	reg  [2:0]   state_next;
	reg          wake_irq_reg;
	reg          resume_reg;
	reg          ack_reg;
	reg  [31:0]  dat_reg;
	reg  [31:0]  rd_word;

	wire [9:0]   adr = {wb_adr_i[9:2], 2'b00};
	wire [3:0]   m_set = adr[7:4];
	wire [1:0]   c_set = adr[5:4];
	wire [1:0]   sub = adr[3:2];
	wire         m_hit = (adr < `ADR_MSET_MAX);
	wire         c_hit = (adr >= `ADR_CSET_BASE) && (adr < `ADR_CSET_MAX);
	wire         r_hit = (adr >= `ADR_ROUTE_BASE) && (adr < `ADR_ROUTE_MAX);
	wire [2:0]   r_idx = adr[4:2] - 3'd0;
	wire         wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
	wire [31:0]  wval;
	wire [65:0]  qual_in;
	wire [65:0]  analog;
	wire [65:0]  nxt_out;
	wire [65:0]  nxt_oe;
	wire [65:0]  ctl_owned;
	wire [5:0]   qual_standby = control_clock_config_reg[7:2];
	wire [1:0]   lpm_bits = control_clock_config_reg[1:0];
	wire         wake_excluded;
	wire         wake_req;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] d;
		input [3:0]  s;
		integer      b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1) begin
				if (s[b])
					merge[b*8 +: 8] = d[b*8 +: 8];
			end
		end
	endfunction

	assign wval = merge(rd_word, wb_dat_i, wb_sel_i);

	// Read view of the addressed register; unmapped words read zero
	always @* begin
		rd_word = 32'h0000_0000;
		if (m_hit) begin
			case (sub)
			`SUB_FUNC: rd_word = port_function_select_reg[m_set*32 +: 32];
			`SUB_PATH: rd_word = {24'h0, alternate_path_select_reg[m_set*8 +: 8]};
			`SUB_DATA: rd_word = {8'h0, pin_sync_reg[m_set*8 +: 8] & {8{m_set != 4'd8}},
				m_dir_reg[m_set*8 +: 8], m_data_reg[m_set*8 +: 8]};
			default:   rd_word = {16'h0, irq_en_reg[m_set*8 +: 8],
				pullup_reg[m_set*8 +: 8]};
			endcase
		end else if (c_hit) begin
			case (sub)
			`SUB_FUNC: rd_word = c_mux_reg[c_set*64 +: 32];
			`SUB_PATH: rd_word = c_mux_reg[c_set*64 + 32 +: 32];
			`SUB_DATA: rd_word = c_data_reg[c_set*32 +: 32];
			default:   rd_word = c_dir_reg[c_set*32 +: 32];
			endcase
		end else if (r_hit) begin
			rd_word = {2'b00, route_sel_reg[r_idx*32 + 24 +: 6],
				2'b00, route_sel_reg[r_idx*32 + 16 +: 6],
				2'b00, route_sel_reg[r_idx*32 + 8 +: 6],
				2'b00, route_sel_reg[r_idx*32 +: 6]};
		end else begin
			case (adr)
			`ADR_AMSEL:   rd_word = {28'h0, analog_mode_select_reg};
			`ADR_LPSTAT:  rd_word = {30'h0, control_lowpower_status_reg};
			`ADR_QUAL0:   rd_word = qual_period_reg[31:0];
			`ADR_QUAL1:   rd_word = qual_period_reg[63:32];
			`ADR_QUAL2:   rd_word = {24'h0, qual_period_reg[71:64]};
			`ADR_CLKCFG:  rd_word = {23'h0, control_clock_config_reg};
			`ADR_WAKESEL: rd_word = {26'h0, wake_sel_reg};
			`ADR_STATUS:  rd_word = {27'h0, wake_req, standby_wake_signal_o,
				state_reg};
			default:      rd_word = 32'h0000_0000;
			endcase
		end
	end

	// Answer one cycle after the request; write lands at the acked edge
	always @(posedge clk_i) begin
		if (reset_i) begin
			ack_reg <= 1'b0;
			dat_reg <= `RESET_VALUE;
		end else begin
			ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
			dat_reg <= rd_word;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	always @(posedge clk_i) begin
		if (reset_i) begin
			port_function_select_reg    <= 288'h0;
			alternate_path_select_reg   <= 72'h0;
			m_data_reg                  <= 72'h0;
			m_dir_reg                   <= 72'h0;
			pullup_reg                  <= 72'h0;
			irq_en_reg                  <= 72'h0;
			c_mux_reg                   <= 192'h0;
			c_data_reg                  <= 96'h0;
			c_dir_reg                   <= 96'h0;
			analog_mode_select_reg      <= 4'h0;
			control_lowpower_status_reg <= 2'h0;
			qual_period_reg             <= 72'h0;
			control_clock_config_reg    <= 9'h000;
			wake_sel_reg                <= 6'h00;
			route_sel_reg               <= 192'h0;
		end else if (wr) begin
			if (m_hit) begin
				case (sub)
				`SUB_FUNC: port_function_select_reg[m_set*32 +: 32] <= wval;
				`SUB_PATH: alternate_path_select_reg[m_set*8 +: 8] <= wval[7:0];
				`SUB_DATA: begin
					m_data_reg[m_set*8 +: 8] <= wval[7:0];
					m_dir_reg[m_set*8 +: 8]  <= wval[15:8];
				end
				default: begin
					pullup_reg[m_set*8 +: 8] <= wval[7:0];
					irq_en_reg[m_set*8 +: 8] <= wval[15:8];
				end
				endcase
			end else if (c_hit) begin
				case (sub)
				`SUB_FUNC: c_mux_reg[c_set*64 +: 32]      <= wval;
				`SUB_PATH: c_mux_reg[c_set*64 + 32 +: 32] <= wval;
				`SUB_DATA: c_data_reg[c_set*32 +: 32]     <= wval;
				default:   c_dir_reg[c_set*32 +: 32]      <= wval;
				endcase
			end else if (r_hit) begin
				route_sel_reg[r_idx*32 +: 6]      <= wval[5:0];
				route_sel_reg[r_idx*32 + 8 +: 6]  <= wval[13:8];
				route_sel_reg[r_idx*32 + 16 +: 6] <= wval[21:16];
				route_sel_reg[r_idx*32 + 24 +: 6] <= wval[29:24];
			end else begin
				case (adr)
				`ADR_AMSEL:   analog_mode_select_reg      <= wval[3:0];
				`ADR_LPSTAT:  control_lowpower_status_reg <= wval[1:0];
				`ADR_QUAL0:   qual_period_reg[31:0]       <= wval;
				`ADR_QUAL1:   qual_period_reg[63:32]      <= wval;
				`ADR_QUAL2:   qual_period_reg[71:64]      <= wval[7:0];
				`ADR_CLKCFG:  control_clock_config_reg    <= wval[8:0];
				`ADR_WAKESEL: wake_sel_reg                <= wval[5:0];
				default:      wake_sel_reg                <= wake_sel_reg;
				endcase
			end
		end
	end

	// Pins are asynchronous to this clock
	always @(posedge clk_i) begin
		if (reset_i) begin
			pin_meta_reg <= 66'h0;
			pin_sync_reg <= 66'h0;
		end else begin
			pin_meta_reg <= pin_in_i;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	assign usb_pll_ref_clock_o = pin_in_i[`PIN_OSC];
	assign can_ext_clock_o     = pin_in_i[`PIN_OSC];

	assign usb_analog_en_o = {analog[`PIN_ID], analog[`PIN_DPLUS],
		analog[`PIN_DMINUS], analog[`PIN_VBUS]};

	genvar p;
	generate
		for (p = 0; p < `NUM_PINS; p = p + 1) begin : g_pin
			wire [3:0] func = port_function_select_reg[p*4 +: 4];
			wire [1:0] cfn  = c_mux_reg[p*2 +: 2];
			wire       m_o;
			wire       m_e;
			wire       c_o;
			wire       c_e;
			if (p == `PIN_VBUS || p == `PIN_ID) begin : g_usb_a
				assign analog[p] = analog_mode_select_reg[p == `PIN_ID ? 3 : 0]
					| (SILICON_REV0 != 0);
			end else if (p == `PIN_DMINUS || p == `PIN_DPLUS) begin : g_usb_b
				assign analog[p] = analog_mode_select_reg[p == `PIN_DPLUS ? 2 : 1];
			end else begin : g_dig
				assign analog[p] = 1'b0;
			end
			assign m_o = (func == 4'h0) ? m_data_reg[p] :
				m_per_out_i[p*15 + func - 1];
			assign m_e = (func == 4'h0) ? m_dir_reg[p] :
				m_per_oe_i[p*15 + func - 1];
			assign c_o = (cfn == 2'h0) ? c_data_reg[p] :
				c_per_out_i[p*3 + cfn - 1];
			assign c_e = (cfn == 2'h0) ? c_dir_reg[p] :
				c_per_oe_i[p*3 + cfn - 1];
			assign ctl_owned[p] = alternate_path_select_reg[p];
			assign nxt_out[p] = ~analog[p] & (ctl_owned[p] ? c_o : m_o);
			assign nxt_oe[p]  = ~analog[p] & (ctl_owned[p] ? c_e : m_e);
		end
	endgenerate

	always @(posedge clk_i) begin
		if (reset_i) begin
			out_reg      <= 66'h0;
			oe_reg       <= 66'h0;
			pull_out_reg <= 66'h0;
			m_in_reg     <= 66'h0;
			c_in_reg     <= 66'h0;
		end else begin
			out_reg      <= nxt_out;
			oe_reg       <= nxt_oe;
			pull_out_reg <= pullup_reg[65:0] & ~analog;
			m_in_reg     <= pin_sync_reg & ~ctl_owned & ~analog;
			c_in_reg     <= pin_sync_reg & ctl_owned & ~analog;
		end
	end

	assign pin_out_o    = out_reg;
	assign pin_oe_o     = oe_reg;
	assign pin_pullup_o = pull_out_reg;
	assign m_pin_in_o   = m_in_reg;
	assign c_pin_in_o   = c_in_reg;

	genvar g;
	generate
		for (g = 0; g < `NUM_MSETS; g = g + 1) begin : g_qual
			localparam W = (g == `NUM_MSETS - 1) ? 2 : 8;
			reg  [7:0]   tick_cnt_reg;
			reg  [W-1:0] s1_reg;
			reg  [W-1:0] s2_reg;
			reg  [W-1:0] q_reg;
			wire [W-1:0] raw = pin_sync_reg[g*8 +: W];
			wire         tick = (tick_cnt_reg == qual_period_reg[g*8 +: 8]);
			integer      k;
			always @(posedge clk_i) begin
				if (reset_i) begin
					tick_cnt_reg <= 8'h00;
					s1_reg       <= {W{1'b0}};
					s2_reg       <= {W{1'b0}};
					q_reg        <= {W{1'b0}};
				end else begin
					tick_cnt_reg <= tick ? 8'h00 : tick_cnt_reg + 8'h01;
					if (tick) begin
						s1_reg <= raw;
						s2_reg <= s1_reg;
						// Three equal samples pass, glitches do not
						for (k = 0; k < W; k = k + 1) begin
							if (raw[k] == s1_reg[k] && s1_reg[k] == s2_reg[k])
								q_reg[k] <= raw[k];
						end
					end
				end
			end
			assign qual_in[g*8 +: W] = q_reg;
			always @(posedge clk_i) begin
				if (reset_i)
					group_irq_reg[g] <= 1'b0;
				else
					group_irq_reg[g] <= |(pin_sync_reg[g*8 +: W]
						& irq_en_reg[g*8 +: W] & ~ctl_owned[g*8 +: W]);
			end
		end
	endgenerate

	assign control_general_inputs_o = qual_in;
	assign port_group_irq_o         = group_irq_reg;

	genvar r;
	generate
		for (r = 0; r < `NUM_ROUTES; r = r + 1) begin : g_route
			wire [5:0] sel = route_sel_reg[(r/4)*32 + (r%4)*8 +: 6];
			always @(posedge clk_i) begin
				if (reset_i)
					route_reg[r] <= 1'b0;
				else
					route_reg[r] <= qual_in[sel] & (sel != `PIN_NOROUTE_A)
						& (sel != `PIN_NOROUTE_B);
			end
		end
	endgenerate

	assign pin_trip_events_o = route_reg[11:0];
	assign capture_in_o      = route_reg[17:12];
	assign ext_int_o         = route_reg[20:18];

	assign wake_excluded = (wake_sel_reg == `PIN_NOROUTE_A)
		| (wake_sel_reg == `PIN_NOROUTE_B);
	assign standby_wake_signal_o = pin_sync_reg[wake_sel_reg] & ~wake_excluded;

	always @(posedge clk_i) begin
		if (reset_i)
			wake_cnt_reg <= 7'h00;
		else if (!standby_wake_signal_o)
			wake_cnt_reg <= 7'h00;
		else if (wake_cnt_reg != `WAKE_CNT_MAX)
			wake_cnt_reg <= wake_cnt_reg + 7'h01;
	end

	assign wake_req = (wake_cnt_reg > {1'b0, qual_standby});

	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_RUN: begin
			if (idle_strobe_i)
				state_next = (lpm_bits == `LPM_STANDBY) ? ST_STBY : ST_IDLE;
		end
		ST_IDLE: begin
			if (control_irq_i)
				state_next = ST_RUN;
		end
		ST_STBY: begin
			if (wake_req | master_to_control_ipc_irq2_i)
				state_next = ST_RUN;
		end
		default: state_next = ST_RUN;
		endcase
	end

	always @(posedge clk_i) begin
		if (reset_i) begin
			state_reg    <= ST_RUN;
			wake_irq_reg <= 1'b0;
			resume_reg   <= 1'b0;
		end else begin
			state_reg    <= state_next;
			resume_reg   <= (state_reg != ST_RUN) & (state_next == ST_RUN);
			wake_irq_reg <= (state_reg == ST_STBY) & (state_next == ST_RUN)
				& control_clock_config_reg[`CLK_WAKEIE_BIT];
		end
	end

	assign control_core_clock_en_o   = state_reg[0];
	assign control_system_clock_en_o = ~state_reg[2];
	assign control_input_clock_en_o  = ~state_reg[2];
	assign wake_irq_o                = wake_irq_reg;
	assign resume_o                  = resume_reg;

endmodule
`default_nettype wire

// >>> test/pin_mux_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pin_mux_checker (
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [65:0] pin_in_i,
	input wire logic [65:0] pin_oe_o,
	input wire logic [65:0] pin_pullup_o,
	input wire logic [65:0] m_pin_in_o,
	input wire logic [65:0] c_pin_in_o,
	input wire logic [3:0]  usb_analog_en_o,
	input wire logic        usb_pll_ref_clock_o,
	input wire logic        can_ext_clock_o,
	input wire logic        idle_strobe_i,
	input wire logic        master_to_control_ipc_irq2_i,
	input wire logic        control_core_clock_en_o,
	input wire logic        control_system_clock_en_o,
	input wire logic        control_input_clock_en_o,
	input wire logic        wake_irq_o,
	input wire logic        resume_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_leave;
		!$past(reset_i) && $rose(control_system_clock_en_o);
	endsequence
	sequence s_pulse;
		resume_o ##1 !resume_o;
	endsequence
	// Analog mode must have settled through the registered pin paths
	sequence s_analog;
		(&usb_analog_en_o) && $past(&usb_analog_en_o);
	endsequence
	a_bus_answer: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse one cycle after request");
	a_reset_quiet: assert property ($fell(reset_i) |->
		pin_oe_o == 66'h0 && pin_pullup_o == 66'h0)
		else $error("drivers or pullups active after reset");
	a_osc_direct: assert property (usb_pll_ref_clock_o == pin_in_i[63]
		&& can_ext_clock_o == pin_in_i[63])
		else $error("oscillator pin not passed straight through");
	a_analog_quiet: assert property (s_analog |-> !pin_oe_o[38]
		&& !pin_oe_o[42] && !pin_oe_o[45] && !pin_oe_o[46]
		&& !m_pin_in_o[38] && !c_pin_in_o[46])
		else $error("analog pin still has a digital path");
	a_owner_excl: assert property ((m_pin_in_o & c_pin_in_o) == 66'h0)
		else $error("pin input returned to both sides");
	a_idle_entry: assert property (control_core_clock_en_o &&
		idle_strobe_i |=> !control_core_clock_en_o)
		else $error("idle strobe did not stop the core clock");
	a_standby_clocks: assert property ((control_system_clock_en_o ==
		control_input_clock_en_o) && (control_system_clock_en_o ||
		!control_core_clock_en_o))
		else $error("clock enables disagree with the mode");
	a_wake_resume: assert property (s_leave |-> s_pulse)
		else $error("leaving standby without one resume pulse");
	a_irq_resume: assert property (wake_irq_o |-> resume_o)
		else $error("wake interrupt without resume");
	a_ipc_exit: assert property (!control_system_clock_en_o &&
		master_to_control_ipc_irq2_i |-> ##[1:2] control_system_clock_en_o)
		else $error("ipc line did not end standby");
endmodule
bind pin_mux_wake pin_mux_checker u_chk (.*);
`default_nettype wire

// >>> test/pin_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
	input  wire logic        clk_i,
	input  wire logic [65:0] pin_out_i,
	input  wire logic [65:0] pin_oe_i,
	input  wire logic [65:0] pin_pullup_i,
	input  wire logic [65:0] ext_en_i,
	input  wire logic [65:0] ext_val_i,
	output wire logic [65:0] pin_level_o
);
	// Floating pins wander so a stale level can never pass as driven
	logic flip = 1'b0;
	always @(posedge clk_i) begin
		flip <= ~flip;
	end
	assign pin_level_o = (pin_oe_i & pin_out_i) |
		(~pin_oe_i & ext_en_i & ext_val_i) |
		(~pin_oe_i & ~ext_en_i & (pin_pullup_i | {66{flip}}));
endmodule
`default_nettype wire

// >>> test/pin_mux_wake_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_regs.vh"
module pin_mux_wake_tb;
	typedef struct { logic [9:0] a; logic [3:0] s; logic [31:0] b, d, e; } row_t;
	logic         clk_i = 1'b0;
	logic         reset_i = 1'b1;
	logic         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [9:0]   wb_adr_i = 10'h0;
	logic [3:0]   wb_sel_i = 4'h0;
	logic [31:0]  wb_dat_i = 32'h0, q;
	logic [989:0] m_per_out_i = 990'h0, m_per_oe_i = 990'h0;
	logic [197:0] c_per_out_i = 198'h0, c_per_oe_i = 198'h0;
	logic         idle_strobe_i = 1'b0, control_irq_i = 1'b0;
	logic         master_to_control_ipc_irq2_i = 1'b0;
	logic [65:0]  ext_en = 66'h0, ext_val = 66'h0;
	wire  [31:0]  wb_dat_o;
	wire  [65:0]  pin_in_i, pin_out_o, pin_oe_o, pin_pullup_o;
	wire  [65:0]  m_pin_in_o, c_pin_in_o, control_general_inputs_o;
	wire  [3:0]   usb_analog_en_o;
	wire  [8:0]   port_group_irq_o;
	wire  [11:0]  pin_trip_events_o;
	wire  [5:0]   capture_in_o;
	wire  [2:0]   ext_int_o;
	wire          wb_ack_o, usb_pll_ref_clock_o, can_ext_clock_o, resume_o;
	wire          standby_wake_signal_o, control_input_clock_en_o, wake_irq_o;
	wire          control_core_clock_en_o, control_system_clock_en_o;
	integer       fail_count = 0, check_count = 0, i;
	row_t rows [10] = '{
		'{10'h014, 4'hf, 32'h0, 32'h1ff, 32'hff},
		'{`ADR_CSET_BASE + 10'h4, 4'hf, 32'h0, 32'hffffffff, 32'hffffffff},
		'{`ADR_QUAL0, 4'hf, 32'h0, 32'h11223344, 32'h11223344},
		'{`ADR_QUAL0, 4'h1, 32'h11223344, 32'hffffffff, 32'h112233ff},
		'{`ADR_LPSTAT, 4'hf, 32'h0, 32'hffffffff, 32'h3},
		'{`ADR_AMSEL, 4'hf, 32'h0, 32'hff, 32'hf},
		'{`ADR_WAKESEL, 4'hf, 32'h0, 32'hff, 32'h3f},
		'{`ADR_CLKCFG, 4'hf, 32'h0, 32'hffffffff, 32'h1ff},
		'{`ADR_ROUTE_BASE, 4'hf, 32'h0, 32'hffffffff, 32'h3f3f3f3f},
		'{10'h3fc, 4'hf, 32'h0, 32'hffffffff, 32'h0}};
	pin_board_model board (
		.clk_i       (clk_i),
		.pin_out_i   (pin_out_o),
		.pin_oe_i    (pin_oe_o),
		.pin_pullup_i(pin_pullup_o),
		.ext_en_i    (ext_en),
		.ext_val_i   (ext_val),
		.pin_level_o (pin_in_i)
	);
	pin_mux_wake #(.SILICON_REV0(0)) uut (.*);
	always #12.5 clk_i = ~clk_i;
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", check_count, fail_count);
			if (fail_count == 0 && check_count > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("mismatch %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task tick(input integer n);
		begin
			repeat (n) @(posedge clk_i);
		end
	endtask
	task bus(input [9:0] a, input [3:0] s, input w, input [31:0] d);
		integer n;
		begin
			wb_cyc_i <= 1'b1;
			wb_stb_i <= 1'b1;
			wb_we_i <= w;
			wb_adr_i <= a;
			wb_sel_i <= s;
			wb_dat_i <= d;
			n = 0;
			@(posedge clk_i);
			while (wb_ack_o !== 1'b1 && n < 20) begin
				n = n + 1;
				@(posedge clk_i);
			end
			q = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			chk("ack", 1, n < 20);
			@(posedge clk_i);
		end
	endtask
	task wait_resume;
		integer n;
		begin
			n = 0;
			while (resume_o !== 1'b1 && n < 40) begin
				n = n + 1;
				tick(1);
			end
			chk("resume", 1, n < 40);
		end
	endtask
	task strobe;
		begin
			idle_strobe_i <= 1'b1;
			tick(1);
			idle_strobe_i <= 1'b0;
			tick(2);
		end
	endtask
	initial begin
		#1000000;
		fail_count = fail_count + 1;
		give_verdict;
	end
	initial begin
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		tick(1);
		chk("oe", 0, |pin_oe_o);
		chk("pull", 0, |pin_pullup_o);
		for (i = 0; i < 10; i = i + 1) begin
			bus(rows[i].a, 4'hf, 0, 32'h0);
			chk("before", rows[i].b, q);
			bus(rows[i].a, rows[i].s, 1, rows[i].d);
			bus(rows[i].a, 4'hf, 0, 32'h0);
			chk("after", rows[i].e, q);
		end
		// Mid-run reset must bring the set 1 path register back
		reset_i <= 1'b1;
		tick(2);
		reset_i <= 1'b0;
		tick(1);
		bus(10'h014, 4'hf, 0, 32'h0);
		chk("path", `RESET_VALUE, q);
		bus(10'h008, 4'hf, 1, 32'h0101);
		tick(1);
		chk("out0", 1, pin_out_o[0] & pin_oe_o[0]);
		bus(10'h00c, 4'hf, 1, 32'h0102);
		tick(1);
		chk("pull1", 1, pin_pullup_o[1]);
		tick(6);
		chk("grpirq", 1, port_group_irq_o[0]);
		ext_en[2] <= 1'b1;
		ext_val[2] <= 1'b1;
		tick(5);
		chk("m_in", 1, m_pin_in_o[2] & ~c_pin_in_o[2]);
		bus(10'h004, 4'hf, 1, 32'h04);
		tick(4);
		chk("c_in", 1, c_pin_in_o[2] & ~m_pin_in_o[2]);
		for (i = 1; i < 16; i = i + 1) begin
			bus(10'h000, 4'hf, 1, i << 4);
			m_per_out_i <= 990'h1 << (14 + i);
			m_per_oe_i <= 990'h1 << (14 + i);
			tick(2);
			chk("m_func", 1, pin_out_o[1] & pin_oe_o[1]);
		end
		bus(10'h004, 4'hf, 1, 32'h0c);
		for (i = 1; i < 4; i = i + 1) begin
			bus(`ADR_CSET_BASE, 4'hf, 1, i << 6);
			c_per_out_i <= 198'h1 << (8 + i);
			c_per_oe_i <= 198'h1 << (8 + i);
			tick(2);
			chk("c_func", 1, pin_out_o[3] & pin_oe_o[3]);
		end
		bus(`ADR_ROUTE_BASE, 4'hf, 1, 32'h2702);
		bus(`ADR_ROUTE_BASE + 10'h00c, 4'hf, 1, 32'h2);
		bus(`ADR_ROUTE_BASE + 10'h010, 4'hf, 1, 32'h00020000);
		ext_en[39] <= 1'b1;
		ext_val[39] <= 1'b1;
		tick(12);
		// Unset routes select pin 0, which is still driven high
		chk("trip", 12'hffd, pin_trip_events_o);
		chk("cap", 1, capture_in_o[0] & ext_int_o[0]);
		chk("gpi", 1, control_general_inputs_o[2]);
		chk("gpi39", 1, control_general_inputs_o[39]);
		bus(`ADR_AMSEL, 4'hf, 1, 32'hf);
		bus(10'h048, 4'hf, 1, 32'h4040);
		ext_en[46] <= 1'b1;
		ext_val[46] <= 1'b1;
		tick(5);
		chk("analog", 4'hf, usb_analog_en_o);
		chk("an_pin", 0, pin_oe_o[38] | m_pin_in_o[46]);
		ext_val[2] <= 1'b0;
		bus(`ADR_WAKESEL, 4'hf, 1, 32'h2);
		bus(`ADR_CLKCFG, 4'hf, 1, 32'h111);
		// Master announces standby in the status mailbox first
		bus(`ADR_LPSTAT, 4'hf, 1, 32'h1);
		bus(`ADR_LPSTAT, 4'hf, 0, 32'h0);
		chk("lpstat", 32'h1, q);
		tick(4);
		chk("wsig", 0, standby_wake_signal_o);
		strobe;
		chk("stby", 0, control_system_clock_en_o);
		ext_val[2] <= 1'b1;
		tick(4);
		ext_val[2] <= 1'b0;
		tick(8);
		chk("short", 0, control_system_clock_en_o);
		ext_val[2] <= 1'b1;
		wait_resume;
		chk("wake_irq", 1, wake_irq_o & control_system_clock_en_o);
		ext_val[2] <= 1'b0;
		tick(6);
		strobe;
		master_to_control_ipc_irq2_i <= 1'b1;
		tick(1);
		master_to_control_ipc_irq2_i <= 1'b0;
		wait_resume;
		chk("ipc", 1, control_system_clock_en_o);
		bus(`ADR_CLKCFG, 4'hf, 1, 32'h0);
		strobe;
		chk("idle", 2'b10, {control_system_clock_en_o,
			control_core_clock_en_o});
		control_irq_i <= 1'b1;
		tick(1);
		control_irq_i <= 1'b0;
		wait_resume;
		chk("no_irq", 0, wake_irq_o);
		give_verdict;
	end
endmodule
`default_nettype wire
